// ### mid_pkg.sv
// Purpose: Constants for the interrupt request and dispatch block
// Assumes: 8-bit register port, 50 MHz core clock
// Notes:   Offsets are byte addresses on the register port
package mid_pkg;

    // Register offsets
    localparam logic [7:0] MID_EDGE_SELECT_ADDR   = 8'hBF;
    localparam logic [7:0] MID_REQ_FLAG_ADDR      = 8'hC8;
    localparam logic [7:0] MID_REQ_ENABLE_ADDR    = 8'hC9;
    localparam logic [7:0] MID_STACK_LEVEL_ADDR   = 8'hDF;

    // Source bit positions, shared by flag and enable registers
    localparam int MID_SRC_EXT   = 0;
    localparam int MID_SRC_MSP   = 1;
    localparam int MID_SRC_SER   = 3;
    localparam int MID_SRC_T0    = 4;
    localparam int MID_SRC_T1    = 6;
    localparam int MID_SRC_CMP   = 7;
    localparam logic [7:0] MID_SRC_IMPL_MASK = 8'hDB;

    // Stack level register fields
    localparam int MID_GIE_BIT   = 7;
    localparam int MID_LEVEL_LSB = 0;
    localparam int MID_LEVEL_W   = 3;
    localparam logic                   MID_GIE_RESET   = 1'b0;
    localparam logic [MID_LEVEL_W-1:0] MID_LEVEL_RESET = 3'h7;

    // Edge select field
    localparam int MID_EDGE_LSB = 3;
    localparam int MID_EDGE_W   = 2;
    localparam logic [MID_EDGE_W-1:0] MID_EDGE_RESET = 2'h2;

    // Shared vector address
    localparam logic [15:0] MID_VECTOR_ADDR = 16'h0008;

    // Program flag status bits kept out of save and restore
    localparam int MID_TIMEOUT_BIT   = 7;
    localparam int MID_POWERDOWN_BIT = 6;
    localparam logic [7:0] MID_FLAG_KEEP_MASK = 8'h3F;

    typedef enum logic [1:0] {
        MID_EDGE_RSVD    = 2'b00,
        MID_EDGE_RISING  = 2'b01,
        MID_EDGE_FALLING = 2'b10,
        MID_EDGE_BOTH    = 2'b11
    } mid_edge_t;

    typedef enum logic [0:0] {
        MID_ST_RUN     = 1'b0,
        MID_ST_SERVICE = 1'b1
    } mid_state_t;

endpackage : mid_pkg

// ### mid_dispatch.sv
// Purpose: Interrupt flags, enables, global enable, vectoring and save buffer
// Assumes: Core asks on instruction boundaries and honours load and push pulses
// Notes:   Shared vector, no hardware priority among sources
// Function
// - No service while global enable is zero
// - Accept loads vector 8, pushes one level
// - Single-entry save and restore of accumulator, flags
// - Timeout and powerdown bits excluded from save
// - External edge sets flag regardless of enable
// - External enable and edge cause vectoring
// - Matching edge in powerdown latched, serviced once powerdown ends
// - Edge field bits 4:3, reset falling
// - Timer zero overflow always sets its flag
// - Timer zero vectors only when enabled
// - Timer one overflow always sets its flag
// - Timer one flag and enable vector
// - Late timer one enable does not vector
// - Serial completion always sets its flag
// - Serial flag and enable vector
// - Late serial enable does not vector
// - Comparator triggers on rising output
// - Comparator trigger sets flag regardless enable
// - Comparator flag never set while disabled
// - Comparator enable and trigger cause vectoring
// - Entry clears global enable, exit sets it
// - Enables at C9, fixed bit positions
// - Flags at C8, software writes clear
// - Return from service pops one level
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module mid_dispatch
    import mid_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Event sources
    input  wire logic        ext_pin_interrupt_i,
    input  wire logic        timer_zero_ovf_i,
    input  wire logic        timer_one_ovf_i,
    input  wire logic        serial_done_i,
    input  wire logic        msp_event_i,
    input  wire logic        comparator_out_i,
    input  wire logic        comparator_enable_i,
    // Core control
    input  wire logic        powerdown_i,
    input  wire logic        boundary_i,
    input  wire logic        return_from_service_i,
    input  wire logic        call_push_i,
    input  wire logic        call_pop_i,
    output logic             irq_pending_o,
    output logic             pc_load_o,
    output logic      [15:0] pc_vector_o,
    output logic             stack_push_o,
    output logic             stack_pop_o,
    output logic             wake_o,
    output logic             in_service_o,
    // Context save and restore
    input  wire logic        save_i,
    input  wire logic        restore_i,
    input  wire logic [7:0]  accumulator_i,
    input  wire logic [7:0]  program_flag_i,
    output logic      [7:0]  accumulator_restore_o,
    output logic      [7:0]  program_flag_restore_o,
    output logic             restore_valid_o
);

    logic                   global_irq_enable_reg;
    logic [MID_LEVEL_W-1:0] stack_level_reg;
    logic [MID_EDGE_W-1:0]  ext_edge_select_reg;
    logic [7:0]             request_enable_reg;
    logic [7:0]             request_flag_reg;
    logic [7:0]             armed_reg;
    logic                   wake_latch_reg;
    mid_state_t             state_reg;
    logic [1:0]             ext_sync_reg;
    logic                   ext_prev_reg;
    logic [1:0]             cmp_sync_reg;
    logic                   cmp_prev_reg;
    logic [2:0]             hist_valid_reg;
    logic [7:0]             acc_buf_reg;
    logic [7:0]             flag_buf_reg;

    logic       ext_rise;
    logic       ext_fall;
    logic       ext_trigger;
    logic       cmp_trigger;
    logic [7:0] src_event;
    logic [7:0] src_ready;
    logic       accept;
    logic       flag_wr;
    logic       enable_wr;
    logic       stack_wr;

    // Pin synchronisers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
            cmp_sync_reg <= 2'h0;
            cmp_prev_reg <= 1'b0;
            hist_valid_reg <= 3'h0;
        end else if (ce_i) begin
            ext_sync_reg <= {ext_sync_reg[0], ext_pin_interrupt_i};
            ext_prev_reg <= ext_sync_reg[1];
            cmp_sync_reg <= {cmp_sync_reg[0], comparator_out_i};
            cmp_prev_reg <= cmp_sync_reg[1];
            hist_valid_reg <= {hist_valid_reg[1:0], 1'b1};
        end
    end

    // Edges ignored until the sync history is full, no false edge after reset
    assign ext_rise = ext_sync_reg[1] & ~ext_prev_reg & hist_valid_reg[2];
    assign ext_fall = ~ext_sync_reg[1] & ext_prev_reg & hist_valid_reg[2];

    // Edge qualification per select code
    always_comb begin
        case (mid_edge_t'(ext_edge_select_reg))
            MID_EDGE_RISING:  ext_trigger = ext_rise;
            MID_EDGE_FALLING: ext_trigger = ext_fall;
            MID_EDGE_BOTH:    ext_trigger = ext_rise | ext_fall;
            default:          ext_trigger = 1'b0;
        endcase
    end

    assign cmp_trigger = cmp_sync_reg[1] & ~cmp_prev_reg & comparator_enable_i
                         & hist_valid_reg[2];

    always_comb begin
        src_event              = 8'h00;
        src_event[MID_SRC_EXT] = ext_trigger;
        src_event[MID_SRC_MSP] = msp_event_i;
        src_event[MID_SRC_SER] = serial_done_i;
        src_event[MID_SRC_T0]  = timer_zero_ovf_i;
        src_event[MID_SRC_T1]  = timer_one_ovf_i;
        src_event[MID_SRC_CMP] = cmp_trigger;
    end

    assign flag_wr   = reg_wr_i && (reg_addr_i == MID_REQ_FLAG_ADDR);
    assign enable_wr = reg_wr_i && (reg_addr_i == MID_REQ_ENABLE_ADDR);
    assign stack_wr  = reg_wr_i && (reg_addr_i == MID_STACK_LEVEL_ADDR);

    // Per-source flag and arming; event set wins over software write
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_src
            if (MID_SRC_IMPL_MASK[gi]) begin : g_impl
                always_ff @(posedge clock_i or negedge nrst_i) begin
                    if (!nrst_i) begin
                        request_flag_reg[gi] <= 1'b0;
                    end else if (ce_i) begin
                        if (src_event[gi]) begin
                            request_flag_reg[gi] <= 1'b1;
                        end else if (flag_wr) begin
                            request_flag_reg[gi] <= reg_wdata_i[gi];
                        end
                    end
                end
                // Armed when the event came in with its enable set, or when software writes the flag to one with its enable set
                always_ff @(posedge clock_i or negedge nrst_i) begin
                    if (!nrst_i) begin
                        armed_reg[gi] <= 1'b0;
                    end else if (ce_i) begin
                        if (src_event[gi] && request_enable_reg[gi]) begin
                            armed_reg[gi] <= 1'b1;
                        end else if (flag_wr && !reg_wdata_i[gi]) begin
                            armed_reg[gi] <= 1'b0;
                        end else if (flag_wr && reg_wdata_i[gi] && request_enable_reg[gi]) begin
                            armed_reg[gi] <= 1'b1;
                        end
                    end
                end
            end else begin : g_none
                assign request_flag_reg[gi] = 1'b0;
                assign armed_reg[gi]        = 1'b0;
            end
        end
    endgenerate

    // Timer one and serial need arming; external also sees the wake latch
    always_comb begin
        src_ready              = request_flag_reg & request_enable_reg;
        src_ready[MID_SRC_T1]  = request_flag_reg[MID_SRC_T1] & request_enable_reg[MID_SRC_T1]
                                 & armed_reg[MID_SRC_T1];
        src_ready[MID_SRC_SER] = request_flag_reg[MID_SRC_SER] & request_enable_reg[MID_SRC_SER]
                                 & armed_reg[MID_SRC_SER];
        src_ready[MID_SRC_EXT] = (request_flag_reg[MID_SRC_EXT] | wake_latch_reg)
                                 & request_enable_reg[MID_SRC_EXT];
    end

    assign irq_pending_o = global_irq_enable_reg && (|src_ready);
    assign accept        = ce_i && boundary_i && irq_pending_o && !powerdown_i;

    // Enable register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            request_enable_reg <= 8'h00;
        end else if (ce_i && enable_wr) begin
            request_enable_reg <= reg_wdata_i & MID_SRC_IMPL_MASK;
        end
    end

    // Edge select register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_edge_select_reg <= MID_EDGE_RESET;
        end else if (ce_i && reg_wr_i && (reg_addr_i == MID_EDGE_SELECT_ADDR)) begin
            ext_edge_select_reg <= reg_wdata_i[MID_EDGE_LSB +: MID_EDGE_W];
        end
    end

    // Global enable: cleared on entry, set on exit
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            global_irq_enable_reg <= MID_GIE_RESET;
        end else if (ce_i) begin
            if (accept) begin
                global_irq_enable_reg <= 1'b0;
            end else if (return_from_service_i) begin
                global_irq_enable_reg <= 1'b1;
            end else if (stack_wr) begin
                global_irq_enable_reg <= reg_wdata_i[MID_GIE_BIT];
            end
        end
    end

    // Stack level counts down on push, up on pop
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stack_level_reg <= MID_LEVEL_RESET;
        end else if (ce_i) begin
            if (accept || call_push_i) begin
                stack_level_reg <= stack_level_reg - 3'h1;
            end else if (return_from_service_i || call_pop_i) begin
                stack_level_reg <= stack_level_reg + 3'h1;
            end else if (stack_wr) begin
                stack_level_reg <= reg_wdata_i[MID_LEVEL_LSB +: MID_LEVEL_W];
            end
        end
    end

    // Service state and dispatch pulses
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= MID_ST_RUN;
            pc_load_o    <= 1'b0;
            stack_push_o <= 1'b0;
            stack_pop_o  <= 1'b0;
            pc_vector_o  <= 16'h0000;
        end else if (ce_i) begin
            pc_load_o    <= accept;
            stack_push_o <= accept;
            stack_pop_o  <= return_from_service_i;
            if (accept) begin
                pc_vector_o <= MID_VECTOR_ADDR;
            end
            case (state_reg)
                MID_ST_RUN: begin
                    if (accept) begin
                        state_reg <= MID_ST_SERVICE;
                    end
                end
                MID_ST_SERVICE: begin
                    if (return_from_service_i) begin
                        state_reg <= MID_ST_RUN;
                    end
                end
                default: begin
                    state_reg <= MID_ST_RUN;
                end
            endcase
        end
    end

    assign in_service_o = (state_reg == MID_ST_SERVICE);

    // Wake-up latch for a matching external edge in power-down
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_latch_reg <= 1'b0;
            wake_o         <= 1'b0;
        end else if (ce_i) begin
            wake_o <= powerdown_i && ext_trigger;
            if (powerdown_i && ext_trigger) begin
                wake_latch_reg <= 1'b1;
            end else if (accept) begin
                wake_latch_reg <= 1'b0;
            end else if (flag_wr && !reg_wdata_i[MID_SRC_EXT]) begin
                wake_latch_reg <= 1'b0;
            end
        end
    end

    // Single-entry context buffer; status bits never captured
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_buf_reg  <= 8'h00;
            flag_buf_reg <= 8'h00;
        end else if (ce_i && save_i) begin
            acc_buf_reg  <= accumulator_i;
            flag_buf_reg <= program_flag_i & MID_FLAG_KEEP_MASK;
        end
    end

    // Restore merges live status bits back in
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            accumulator_restore_o  <= 8'h00;
            program_flag_restore_o <= 8'h00;
            restore_valid_o        <= 1'b0;
        end else if (ce_i) begin
            restore_valid_o <= restore_i;
            if (restore_i) begin
                accumulator_restore_o  <= acc_buf_reg;
                program_flag_restore_o <= (flag_buf_reg & MID_FLAG_KEEP_MASK)
                                          | (program_flag_i & ~MID_FLAG_KEEP_MASK);
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    MID_EDGE_SELECT_ADDR: begin
                        reg_rdata_o[MID_EDGE_LSB +: MID_EDGE_W] <= ext_edge_select_reg;
                    end
                    MID_REQ_FLAG_ADDR: begin
                        reg_rdata_o <= request_flag_reg;
                    end
                    MID_REQ_ENABLE_ADDR: begin
                        reg_rdata_o <= request_enable_reg;
                    end
                    MID_STACK_LEVEL_ADDR: begin
                        reg_rdata_o[MID_GIE_BIT] <= global_irq_enable_reg;
                        reg_rdata_o[MID_LEVEL_LSB +: MID_LEVEL_W] <= stack_level_reg;
                    end
                    default: begin
                        reg_rdata_o <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Software side relies on the flag readback above

endmodule : mid_dispatch

`default_nettype wire

// ### mid_dispatch_checker.sv
// Purpose: Port-level checks of the interrupt dispatch block
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Attached to every dispatch instance by bind
`timescale 1ns/100ps
`default_nettype none

module mid_dispatch_checker
    import mid_pkg::*;
(
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        ce_i,
    // Watched ports
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        boundary_i,
    input wire logic        powerdown_i,
    input wire logic        return_from_service_i,
    input wire logic        restore_i,
    input wire logic        irq_pending_o,
    input wire logic        pc_load_o,
    input wire logic [15:0] pc_vector_o,
    input wire logic        stack_push_o,
    input wire logic        stack_pop_o,
    input wire logic        wake_o,
    input wire logic        in_service_o,
    input wire logic        restore_valid_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    AST_ACCEPT: assert property (irq_pending_o && boundary_i && !powerdown_i && ce_i |=> pc_load_o)
        else $error("ready request not accepted");
    AST_REFUSE: assert property (!irq_pending_o || !boundary_i || powerdown_i |=> !pc_load_o)
        else $error("vector load without a ready request");
    AST_VECTOR: assert property (pc_load_o |-> pc_vector_o == MID_VECTOR_ADDR)
        else $error("vector address wrong");
    AST_PUSH: assert property (pc_load_o == stack_push_o)
        else $error("stack push not paired with vector load");
    AST_ENTRY: assert property (pc_load_o |-> in_service_o && !irq_pending_o)
        else $error("global enable not cleared on entry");
    AST_RETURN: assert property (return_from_service_i && ce_i |=> stack_pop_o ##1 !stack_pop_o)
        else $error("return did not pop one level");
    AST_EXIT: assert property (return_from_service_i && ce_i |=> !in_service_o)
        else $error("service state held after return");
    AST_WAKE: assert property (wake_o |-> $past(powerdown_i))
        else $error("wake pulse outside power-down");
    AST_RESTORE: assert property (restore_i && ce_i |=> restore_valid_o ##1 !restore_valid_o)
        else $error("restore pulse wrong");
    AST_RDATA: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
endmodule : mid_dispatch_checker

bind mid_dispatch mid_dispatch_checker chk (.*);

`default_nettype wire

// ### mid_core_model.sv
// Purpose: Core-side partner: instruction boundaries and service return
// Assumes: Return is issued a fixed number of cycles into service
// Notes:   slow_i stretches the service routine
`timescale 1ns/100ps
`default_nettype none

module mid_core_model (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // Core handshake
    input  wire logic slow_i,
    input  wire logic service_i,
    output logic      boundary_o,
    output logic      return_o
);
    logic [5:0] wait_reg;

    assign boundary_o = nrst_i;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_reg <= 6'h00;
            return_o <= 1'b0;
        end else begin
            wait_reg <= service_i ? wait_reg + 6'h01 : 6'h00;
            return_o <= service_i && (wait_reg == (slow_i ? 6'h18 : 6'h06));
        end
    end
endmodule : mid_core_model

`default_nettype wire

// ### test_mid_dispatch.sv
// Purpose: Self-checking bench of the interrupt dispatch block
// Assumes: Register port and event sources driven on rising edges
// Notes:   Core partner returns from service on its own
`timescale 1ns/100ps
`default_nettype none

module test_mid_dispatch;
    import mid_pkg::*;
    logic        clock_i, nrst_i, reg_wr_i, reg_rd_i, boundary_i, return_from_service_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, accumulator_i, program_flag_i;
    logic [7:0]  accumulator_restore_o, program_flag_restore_o;
    logic        ext_pin_interrupt_i, timer_zero_ovf_i, timer_one_ovf_i, serial_done_i;
    logic        msp_event_i, comparator_out_i, comparator_enable_i, powerdown_i;
    logic        irq_pending_o, pc_load_o, stack_push_o, stack_pop_o, wake_o, in_service_o;
    logic        save_i, restore_i, restore_valid_o, slow;
    logic        ce_i, call_push_i, call_pop_i;
    logic [15:0] pc_vector_o;
    int          error_cnt, total_checks, loads, wakes;
    int          srcs[6] = '{MID_SRC_EXT, MID_SRC_MSP, MID_SRC_SER, MID_SRC_T0, MID_SRC_T1, MID_SRC_CMP};
    int          lt[3] = '{MID_SRC_T0, MID_SRC_T1, MID_SRC_SER};

    mid_dispatch dut (.*);
    mid_core_model core (.clock_i(clock_i), .nrst_i(nrst_i), .slow_i(slow), .service_i(in_service_o),
                         .boundary_o(boundary_i), .return_o(return_from_service_i));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        if (pc_load_o === 1'b1) loads++;
        if (wake_o === 1'b1) wakes++;
    end

    task automatic print_verdict;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic give_up;
        error_cnt++;
        print_verdict;
    endtask : give_up

    initial begin
        repeat (60000) @(posedge clock_i);
        give_up;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        repeat (3) @(posedge clock_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk(nm, {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rdchk

    task automatic fire(input int s);
        @(posedge clock_i);
        case (s)
            MID_SRC_EXT: ext_pin_interrupt_i <= ~ext_pin_interrupt_i;
            MID_SRC_MSP: msp_event_i <= 1'b1;
            MID_SRC_SER: serial_done_i <= 1'b1;
            MID_SRC_T0:  timer_zero_ovf_i <= 1'b1;
            MID_SRC_T1:  timer_one_ovf_i <= 1'b1;
            default:     comparator_out_i <= ~comparator_out_i;
        endcase
        @(posedge clock_i);
        {msp_event_i, serial_done_i, timer_zero_ovf_i, timer_one_ovf_i} <= 4'h0;
    endtask : fire

    task automatic wait_loads;
        int n;
        for (n = 0; n < 30 && loads == 0; n++) @(posedge clock_i);
        if (n == 30) give_up;
    endtask : wait_loads

    task automatic t_reset;
        rdchk("edge", MID_EDGE_SELECT_ADDR, 8'h10);
        rdchk("flags", MID_REQ_FLAG_ADDR, 8'h00);
        rdchk("enables", MID_REQ_ENABLE_ADDR, 8'h00);
        rdchk("stack", MID_STACK_LEVEL_ADDR, 8'h07);
        rdchk("unmapped", 8'h00, 8'h00);
        wr(MID_REQ_ENABLE_ADDR, 8'h10);
        loads = 0;
        fire(MID_SRC_T0);
        rdchk("flags", MID_REQ_FLAG_ADDR, 8'h10);
        chk("loads", 16'(loads), 16'h0);
        wr(MID_REQ_FLAG_ADDR, 8'h00);
        rdchk("flags", MID_REQ_FLAG_ADDR, 8'h00);
        wr(MID_REQ_ENABLE_ADDR, 8'h00);
    endtask : t_reset

    task automatic t_dispatch;
        int n;
        slow = 1'b1;
        foreach (srcs[i]) begin
            wr(MID_REQ_ENABLE_ADDR, 8'h01 << srcs[i]);
            wr(MID_STACK_LEVEL_ADDR, 8'h87);
            loads = 0;
            fire(srcs[i]);
            wait_loads;
            chk("vector", pc_vector_o, MID_VECTOR_ADDR);
            wr(MID_REQ_FLAG_ADDR, 8'h00);
            rdchk("level in", MID_STACK_LEVEL_ADDR, 8'h06);
            for (n = 0; n < 60 && in_service_o !== 1'b0; n++) @(posedge clock_i);
            if (n == 60) give_up;
            rdchk("level out", MID_STACK_LEVEL_ADDR, 8'h87);
            chk("loads", 16'(loads), 16'h1);
            wr(MID_REQ_ENABLE_ADDR, 8'h00);
        end
    endtask : t_dispatch

    task automatic t_late;
        foreach (lt[i]) begin
            loads = 0;
            fire(lt[i]);
            rdchk("flag", MID_REQ_FLAG_ADDR, 8'h01 << lt[i]);
            if (i > 0) wr(MID_REQ_ENABLE_ADDR, 8'h01 << lt[i]);
            repeat (8) @(posedge clock_i);
            chk("loads", 16'(loads), 16'h0);
            wr(MID_REQ_FLAG_ADDR, 8'h00);
            wr(MID_REQ_ENABLE_ADDR, 8'h00);
        end
    endtask : t_late

    task automatic t_edges;
        for (int c = 0; c < 4; c++) begin
            wr(MID_EDGE_SELECT_ADDR, 8'(c << MID_EDGE_LSB));
            rdchk("edge", MID_EDGE_SELECT_ADDR, 8'(c << MID_EDGE_LSB));
            wr(MID_REQ_FLAG_ADDR, 8'h00);
            fire(MID_SRC_EXT);
            rdchk("rise", MID_REQ_FLAG_ADDR, {7'h0, c == 1 || c == 3});
            wr(MID_REQ_FLAG_ADDR, 8'h00);
            fire(MID_SRC_EXT);
            rdchk("fall", MID_REQ_FLAG_ADDR, {7'h0, c >= 2});
        end
        wr(MID_REQ_FLAG_ADDR, 8'h00);
    endtask : t_edges

    task automatic t_cmp;
        comparator_enable_i <= 1'b0;
        fire(MID_SRC_CMP);
        fire(MID_SRC_CMP);
        rdchk("cmp off", MID_REQ_FLAG_ADDR, 8'h00);
        comparator_enable_i <= 1'b1;
        fire(MID_SRC_CMP);
        rdchk("cmp fall", MID_REQ_FLAG_ADDR, 8'h00);
        fire(MID_SRC_CMP);
        rdchk("cmp rise", MID_REQ_FLAG_ADDR, 8'h80);
        wr(MID_REQ_FLAG_ADDR, 8'h00);
    endtask : t_cmp

    task automatic t_wake;
        slow = 1'b0;
        wr(MID_EDGE_SELECT_ADDR, 8'h10);
        wr(MID_REQ_ENABLE_ADDR, 8'h01);
        loads = 0;
        wakes = 0;
        powerdown_i <= 1'b1;
        fire(MID_SRC_EXT);
        rdchk("flag", MID_REQ_FLAG_ADDR, 8'h00);
        chk("no wake", 16'(wakes), 16'h0);
        fire(MID_SRC_EXT);
        repeat (6) @(posedge clock_i);
        chk("wake", 16'(wakes), 16'h1);
        chk("held", 16'(loads), 16'h0);
        powerdown_i <= 1'b0;
        wait_loads;
        wr(MID_REQ_FLAG_ADDR, 8'h00);
        wr(MID_REQ_ENABLE_ADDR, 8'h00);
        repeat (20) @(posedge clock_i);
        chk("loads", 16'(loads), 16'h1);
    endtask : t_wake

    task automatic t_save;
        @(posedge clock_i);
        accumulator_i  <= 8'h5A;
        program_flag_i <= 8'hFF;
        save_i         <= 1'b1;
        @(posedge clock_i);
        accumulator_i  <= 8'hA5;
        program_flag_i <= 8'h81;
        @(posedge clock_i);
        save_i         <= 1'b0;
        program_flag_i <= 8'h40;
        restore_i      <= 1'b1;
        @(posedge clock_i);
        restore_i      <= 1'b0;
        #1;
        chk("acc", {8'h00, accumulator_restore_o}, 16'h00A5);
        chk("program_flag_register", {8'h00, program_flag_restore_o},
            {8'h00, (8'h81 & MID_FLAG_KEEP_MASK) | (8'h40 & ~MID_FLAG_KEEP_MASK)});
        chk("valid", {15'h0000, restore_valid_o}, 16'h0001);
    endtask : t_save

    task automatic t_hold;
        @(posedge clock_i);
        ce_i <= 1'b0;
        fire(MID_SRC_T0);
        @(posedge clock_i);
        ce_i        <= 1'b1;
        call_push_i <= 1'b1;
        @(posedge clock_i);
        call_push_i <= 1'b0;
        rdchk("frozen", MID_REQ_FLAG_ADDR, 8'h00);
        rdchk("push", MID_STACK_LEVEL_ADDR, 8'h86);
        @(posedge clock_i);
        call_pop_i <= 1'b1;
        @(posedge clock_i);
        call_pop_i <= 1'b0;
        rdchk("pop", MID_STACK_LEVEL_ADDR, 8'h87);
    endtask : t_hold

    initial begin
        {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {timer_zero_ovf_i, timer_one_ovf_i, serial_done_i, msp_event_i} = 4'h0;
        {comparator_out_i, powerdown_i, save_i, restore_i, slow} = 5'h00;
        {ce_i, call_push_i, call_pop_i} = 3'h4;
        {accumulator_i, program_flag_i} = 16'h0000;
        ext_pin_interrupt_i = 1'b1;
        comparator_enable_i = 1'b1;
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_reset;
        t_dispatch;
        t_late;
        t_edges;
        t_cmp;
        t_wake;
        t_save;
        t_hold;
        print_verdict;
    end
endmodule : test_mid_dispatch

`default_nettype wire
